// ==== src/p1ss_pkg.sv ====
// p1ss_pkg: constants and types for the port 1 soft strap default block.
// assumes a 32-bit classic Wishbone slave map and one 125 MHz clock.
// Behaviour
// RULE_01: speed strap seeds speed select bit
// RULE_02: speed strap seeds 10M advertise, mode
// RULE_03: duplex strap seeds duplex mode bit
// RULE_04: duplex strap seeds 10M full advertise, mode
// RULE_05: backpressure strap seeds backpressure enable bit
// RULE_06: pause strap seeds tx and rx pause
// RULE_07: pause bits act only under manual selection
// RULE_08: capture at reset release; EEPROM overrides
// RULE_09: no valid EEPROM restores captured values
// RULE_10: software writes win until next reseed
package p1ss_pkg;

  // strap group, one bit each, carried together
  typedef struct packed {
    logic speed;
    logic duplex;
    logic backpressure;
    logic pause;
  } p1ss_strap_t;

  // loader controller states, gray along settle-capture-apply-run
  typedef enum logic [1:0] {
    ST_SETTLE  = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_APPLY   = 2'b11,
    ST_RUN     = 2'b10
  } p1ss_state_t;

  // register byte offsets
  localparam logic [7:0] OFS_BASIC_CTRL = 8'h00;
  localparam logic [7:0] OFS_AN_ADV = 8'h04;
  localparam logic [7:0] OFS_SPECIAL_MODE = 8'h08;
  localparam logic [7:0] OFS_MANUAL_FLOW = 8'h0c;
  localparam logic [7:0] OFS_STRAP_STAT = 8'h10;

  // field positions
  localparam int BIT_RATE_SEL = 13;
  localparam int BIT_DUPLEX = 8;
  localparam int BIT_ADV_10FD = 6;
  localparam int BIT_ADV_10HD = 5;
  localparam int BIT_MODE_LSB = 5;
  localparam int BIT_RX_PAUSE = 0;
  localparam int BIT_TX_PAUSE = 1;
  localparam int BIT_BP_EN = 2;
  localparam int BIT_MANUAL_SEL = 3;
  localparam int BIT_STAT_EFF_LSB = 4;
  localparam int BIT_STAT_EE = 8;
  localparam int BIT_STAT_READY = 9;

  // reset values
  localparam p1ss_strap_t STRAP_DEFAULT = 4'hf;
  localparam logic MANUAL_SEL_RESET = 1'b0;
  localparam logic [2:0] MODE_RESET = 3'h3;

  // cycles after reset release before straps are sampled (two synchroniser stages)
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;

endpackage

// ==== src/p1ss_sync.sv ====
// p1ss_sync: two flip-flop level synchroniser, width set by parameter.
// assumes the input is quasi-static; bits may resolve in different cycles.
`timescale 1ns/1ns
module p1ss_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // level in and out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // p1ss_sync

// ==== src/p1ss_top.sv ====
// p1ss_top: port 1 soft strap capture, override and register seeding.
// assumes RSTN_I covers power-on and external_reset_pin; loader inputs on MCLK_I.
`timescale 1ns/1ns
module p1ss_top (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  // strap pins, asynchronous
  input p1ss_pkg::p1ss_strap_t STRAP_PINS_I,
  // eeprom loader and digital reset, same clock
  input wire logic EE_LOAD_I,
  input wire logic EE_VALID_I,
  input p1ss_pkg::p1ss_strap_t EE_STRAP_I,
  input wire logic DIG_RST_I,
  // classic wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // effective port 1 settings
  output logic SPEED_100_O,
  output logic FULL_DUPLEX_O,
  output logic BACKPRESSURE_EN_O,
  output logic TX_PAUSE_ACTIVE_O,
  output logic RX_PAUSE_ACTIVE_O,
  output logic READY_O
);

  logic [1:0] rst_sync_q;
  logic rst_n;
  p1ss_pkg::p1ss_strap_t pins_sync;

  // reset release through two flops; assertion is asynchronous
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // strap pins enter through the synchroniser
  p1ss_sync #(
    .WIDTH(4),
    .INIT(p1ss_pkg::STRAP_DEFAULT)
  ) u_pin_sync (
    .clk_i(MCLK_I),
    .rst_n_i(rst_n),
    .async_i(STRAP_PINS_I),
    .sync_o(pins_sync)
  );

  // controller and strap state
  p1ss_pkg::p1ss_state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  p1ss_pkg::p1ss_strap_t latched_q, latched_d;
  p1ss_pkg::p1ss_strap_t eff_q, eff_d;
  logic from_ee_q, from_ee_d;
  logic reseed_evt;

  assign reseed_evt = (EE_LOAD_I || DIG_RST_I) && (state_q == p1ss_pkg::ST_RUN || state_q == p1ss_pkg::ST_APPLY);

  // capture once after release, then override or restore on request
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    latched_d = latched_q;
    eff_d = eff_q;
    from_ee_d = from_ee_q;
    case (state_q)
      p1ss_pkg::ST_SETTLE:
      begin
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == p1ss_pkg::SETTLE_CYCLES - 2'h1)
          state_d = p1ss_pkg::ST_CAPTURE;
      end
      p1ss_pkg::ST_CAPTURE:
      begin
        latched_d = pins_sync; // RULE_08
        eff_d = pins_sync;
        state_d = p1ss_pkg::ST_APPLY;
      end
      p1ss_pkg::ST_APPLY, p1ss_pkg::ST_RUN:
      begin
        state_d = p1ss_pkg::ST_RUN;
        if (reseed_evt)
        begin
          state_d = p1ss_pkg::ST_APPLY;
          if (EE_LOAD_I && EE_VALID_I)
          begin
            eff_d = EE_STRAP_I; // RULE_08
            from_ee_d = 1'b1;
          end
          else
          begin
            eff_d = latched_q; // RULE_09
            from_ee_d = 1'b0;
          end
        end
      end
      default:
        state_d = p1ss_pkg::ST_SETTLE;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= p1ss_pkg::ST_SETTLE;
      cnt_q <= 2'h0;
      latched_q <= p1ss_pkg::STRAP_DEFAULT;
      eff_q <= p1ss_pkg::STRAP_DEFAULT;
      from_ee_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      latched_q <= latched_d;
      eff_q <= eff_d;
      from_ee_q <= from_ee_d;
    end
  end

  // mode field: 000 10 half, 001 10 full, 010 100 half, 011 100 full
  function automatic logic [2:0] mode_of(input p1ss_pkg::p1ss_strap_t s);
    mode_of = {1'b0, s.speed, s.duplex}; // RULE_02 RULE_04
  endfunction

  // register fields
  logic speed_q, speed_d;
  logic duplex_q, duplex_d;
  logic adv_fd_q, adv_fd_d;
  logic adv_hd_q, adv_hd_d;
  logic [2:0] mode_q, mode_d;
  logic bp_q, bp_d;
  logic txp_q, txp_d;
  logic rxp_q, rxp_d;
  logic man_q, man_d;
  logic wr_stb;
  logic lo_en, hi_en;

  assign wr_stb = CYC_I && STB_I && WE_I && !ACK_O;
  assign lo_en = SEL_I[0];
  assign hi_en = SEL_I[1];

  // seeding outranks a write in the same cycle; writes hold until the next seed
  always_comb
  begin
    speed_d = speed_q;
    duplex_d = duplex_q;
    adv_fd_d = adv_fd_q;
    adv_hd_d = adv_hd_q;
    mode_d = mode_q;
    bp_d = bp_q;
    txp_d = txp_q;
    rxp_d = rxp_q;
    man_d = man_q;
    if (state_q == p1ss_pkg::ST_APPLY)
    begin
      speed_d = eff_q.speed; // RULE_01
      duplex_d = eff_q.duplex; // RULE_03
      adv_fd_d = eff_q.duplex & ~eff_q.speed; // RULE_02 RULE_04
      adv_hd_d = ~eff_q.speed; // RULE_02
      mode_d = mode_of(eff_q); // RULE_02 RULE_04
      bp_d = eff_q.backpressure; // RULE_05
      txp_d = eff_q.pause; // RULE_06
      rxp_d = eff_q.pause; // RULE_06
      man_d = p1ss_pkg::MANUAL_SEL_RESET;
    end
    else if (wr_stb)
    begin
      case (ADR_I)
        p1ss_pkg::OFS_BASIC_CTRL:
        begin
          if (hi_en)
            speed_d = DAT_I[p1ss_pkg::BIT_RATE_SEL]; // RULE_10
          if (hi_en)
            duplex_d = DAT_I[p1ss_pkg::BIT_DUPLEX]; // RULE_10
        end
        p1ss_pkg::OFS_AN_ADV:
        begin
          if (lo_en)
          begin
            adv_fd_d = DAT_I[p1ss_pkg::BIT_ADV_10FD]; // RULE_10
            adv_hd_d = DAT_I[p1ss_pkg::BIT_ADV_10HD];
          end
        end
        p1ss_pkg::OFS_SPECIAL_MODE:
        begin
          if (lo_en)
            mode_d = DAT_I[p1ss_pkg::BIT_MODE_LSB +: 3]; // RULE_10
        end
        p1ss_pkg::OFS_MANUAL_FLOW:
        begin
          if (lo_en)
          begin
            rxp_d = DAT_I[p1ss_pkg::BIT_RX_PAUSE]; // RULE_10
            txp_d = DAT_I[p1ss_pkg::BIT_TX_PAUSE];
            bp_d = DAT_I[p1ss_pkg::BIT_BP_EN];
            man_d = DAT_I[p1ss_pkg::BIT_MANUAL_SEL];
          end
        end
        default:
        begin
          speed_d = speed_q;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      speed_q <= p1ss_pkg::STRAP_DEFAULT.speed;
      duplex_q <= p1ss_pkg::STRAP_DEFAULT.duplex;
      adv_fd_q <= 1'b0;
      adv_hd_q <= 1'b0;
      mode_q <= p1ss_pkg::MODE_RESET;
      bp_q <= p1ss_pkg::STRAP_DEFAULT.backpressure;
      txp_q <= p1ss_pkg::STRAP_DEFAULT.pause;
      rxp_q <= p1ss_pkg::STRAP_DEFAULT.pause;
      man_q <= p1ss_pkg::MANUAL_SEL_RESET;
    end
    else
    begin
      speed_q <= speed_d;
      duplex_q <= duplex_d;
      adv_fd_q <= adv_fd_d;
      adv_hd_q <= adv_hd_d;
      mode_q <= mode_d;
      bp_q <= bp_d;
      txp_q <= txp_d;
      rxp_q <= rxp_d;
      man_q <= man_d;
    end
  end

  // bus answer and live outputs
  logic ack_d;
  logic [31:0] rdat_d;
  logic txa_q, txa_d;
  logic rxa_q, rxa_d;

  always_comb
  begin
    ack_d = CYC_I && STB_I && !ACK_O;
    rdat_d = 32'h0;
    case (ADR_I)
      p1ss_pkg::OFS_BASIC_CTRL:
      begin
        rdat_d[p1ss_pkg::BIT_RATE_SEL] = speed_q;
        rdat_d[p1ss_pkg::BIT_DUPLEX] = duplex_q;
      end
      p1ss_pkg::OFS_AN_ADV:
      begin
        rdat_d[p1ss_pkg::BIT_ADV_10FD] = adv_fd_q;
        rdat_d[p1ss_pkg::BIT_ADV_10HD] = adv_hd_q;
      end
      p1ss_pkg::OFS_SPECIAL_MODE:
        rdat_d[p1ss_pkg::BIT_MODE_LSB +: 3] = mode_q;
      p1ss_pkg::OFS_MANUAL_FLOW:
      begin
        rdat_d[p1ss_pkg::BIT_RX_PAUSE] = rxp_q;
        rdat_d[p1ss_pkg::BIT_TX_PAUSE] = txp_q;
        rdat_d[p1ss_pkg::BIT_BP_EN] = bp_q;
        rdat_d[p1ss_pkg::BIT_MANUAL_SEL] = man_q;
      end
      p1ss_pkg::OFS_STRAP_STAT:
      begin
        rdat_d[3:0] = latched_q;
        rdat_d[p1ss_pkg::BIT_STAT_EFF_LSB +: 4] = eff_q;
        rdat_d[p1ss_pkg::BIT_STAT_EE] = from_ee_q;
        rdat_d[p1ss_pkg::BIT_STAT_READY] = (state_q == p1ss_pkg::ST_RUN);
      end
      default:
        rdat_d = 32'h0; // unmapped reads zero, still acked
    endcase
    // pause bits only steer the mac under manual selection in full duplex
    txa_d = man_q && duplex_q && txp_q; // RULE_07
    rxa_d = man_q && duplex_q && rxp_q; // RULE_07
  end

  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0;
      txa_q <= 1'b0;
      rxa_q <= 1'b0;
    end
    else
    begin
      ACK_O <= ack_d;
      DAT_O <= rdat_d;
      txa_q <= txa_d;
      rxa_q <= rxa_d;
    end
  end

  assign SPEED_100_O = speed_q;
  assign FULL_DUPLEX_O = duplex_q;
  assign BACKPRESSURE_EN_O = bp_q;
  assign TX_PAUSE_ACTIVE_O = txa_q;
  assign RX_PAUSE_ACTIVE_O = rxa_q;
  assign READY_O = (state_q == p1ss_pkg::ST_RUN);

  // checks on seeding, pause gating, capture, restore and write precedence
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!rst_n);

  sequence s_apply;
    state_q == p1ss_pkg::ST_APPLY;
  endsequence

  sequence s_plain_reseed;
    state_q == p1ss_pkg::ST_RUN && DIG_RST_I && !EE_LOAD_I;
  endsequence

  a_speed_seed: assert property (s_apply |=> speed_q == $past(eff_q.speed)) // RULE_01
    else $error("speed bit not seeded from strap");
  a_adv_seed: assert property (s_apply |=> adv_hd_q == !$past(eff_q.speed)) // RULE_02
    else $error("10M half advertise not seeded");
  a_duplex_seed: assert property (s_apply |=> duplex_q == $past(eff_q.duplex)) // RULE_03
    else $error("duplex bit not seeded from strap");
  a_mode_seed: assert property (s_apply |=> mode_q == {1'b0, $past(eff_q.speed), $past(eff_q.duplex)}) // RULE_04
    else $error("mode field not seeded from straps");
  a_bp_seed: assert property (s_apply |=> BACKPRESSURE_EN_O == $past(eff_q.backpressure)) // RULE_05
    else $error("backpressure enable not seeded");
  a_pause_seed: assert property (s_apply |=> txp_q == $past(eff_q.pause) && rxp_q == $past(eff_q.pause)) // RULE_06
    else $error("pause enables not seeded");
  a_pause_gate: assert property (!man_q |=> !TX_PAUSE_ACTIVE_O && !RX_PAUSE_ACTIVE_O) // RULE_07
    else $error("pause active without manual selection");
  a_capture_pins: assert property (state_q == p1ss_pkg::ST_CAPTURE |=> s_apply ##0 latched_q == $past(pins_sync)) // RULE_08
    else $error("straps not captured then applied");
  a_restore_latch: assert property (s_plain_reseed |=> eff_q == latched_q && $stable(latched_q) ##1 speed_q == latched_q.speed) // RULE_09
    else $error("captured straps not restored");
  a_write_holds: assert property (wr_stb && ADR_I == p1ss_pkg::OFS_BASIC_CTRL && SEL_I[1] && state_q == p1ss_pkg::ST_RUN
    |=> speed_q == $past(DAT_I[p1ss_pkg::BIT_RATE_SEL])) // RULE_10
    else $error("software write to speed bit lost");

endmodule // p1ss_top

// ==== tb/p1ss_loader_model.sv ====
// p1ss_loader_model: loader and digital reset source for port 1 straps.
// assumes the bench calls pulse() and shares the block's clock.
`timescale 1ns/1ns
module p1ss_loader_model (
  // clock
  input wire logic clk_i,
  // loader side
  output logic ee_load_o,
  output logic ee_valid_o,
  output p1ss_pkg::p1ss_strap_t ee_strap_o,
  output logic dig_rst_o
);
  // idle until the bench asks for a pulse
  initial
  begin
    ee_load_o = 1'b0;
    ee_valid_o = 1'b0;
    ee_strap_o = 4'h0;
    dig_rst_o = 1'b0;
  end

  // one-cycle request; data lines are scrambled after it so stale values never pass
  task automatic pulse(input logic dig, input logic valid, input p1ss_pkg::p1ss_strap_t s);
    @(posedge clk_i);
    ee_load_o <= ~dig;
    dig_rst_o <= dig;
    ee_valid_o <= valid;
    ee_strap_o <= s;
    @(posedge clk_i);
    ee_load_o <= 1'b0;
    dig_rst_o <= 1'b0;
    ee_valid_o <= ~valid;
    ee_strap_o <= ~s;
  endtask
endmodule // p1ss_loader_model

// ==== tb/p1ss_top_tb.sv ====
// p1ss_top_tb: self-checking bench for the port 1 strap default block.
// assumes the design package, top and loader model are compiled first.
`timescale 1ns/1ns
module p1ss_top_tb;
  logic clk;
  logic rstn;
  p1ss_pkg::p1ss_strap_t pins;
  logic ee_load, ee_valid, dig_rst;
  p1ss_pkg::p1ss_strap_t ee_strap;
  logic cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dat_o;
  logic ack, spd, fdx, bp, txp, rxp, rdy;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;

  p1ss_top u_dut (.MCLK_I(clk), .RSTN_I(rstn), .STRAP_PINS_I(pins), .EE_LOAD_I(ee_load),
    .EE_VALID_I(ee_valid), .EE_STRAP_I(ee_strap), .DIG_RST_I(dig_rst), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack),
    .SPEED_100_O(spd), .FULL_DUPLEX_O(fdx), .BACKPRESSURE_EN_O(bp), .TX_PAUSE_ACTIVE_O(txp),
    .RX_PAUSE_ACTIVE_O(rxp), .READY_O(rdy));

  p1ss_loader_model u_ldr (.clk_i(clk), .ee_load_o(ee_load), .ee_valid_o(ee_valid),
    .ee_strap_o(ee_strap), .dig_rst_o(dig_rst));

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // register image expected from effective and captured straps
  function automatic logic [31:0] exp_reg(input int i, input p1ss_pkg::p1ss_strap_t e,
    input p1ss_pkg::p1ss_strap_t c, input logic ee);
    case (i)
      0: return {18'h0, e.speed, 4'h0, e.duplex, 8'h0};
      1: return {25'h0, e.duplex & ~e.speed, ~e.speed, 5'h0};
      2: return {24'h0, 1'b0, e.speed, e.duplex, 5'h0};
      3: return {29'h0, e.backpressure, e.pause, e.pause};
      4: return {22'h0, 1'b1, ee, e, c};
      default: return 32'h0;
    endcase
  endfunction

  // classic cycle; only the global guard ends the wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 4'hf, 32'h0, r);
    chk(r, e);
  endtask

  task automatic check_all(input p1ss_pkg::p1ss_strap_t e, input p1ss_pkg::p1ss_strap_t c, input logic ee);
    for (int i = 0; i < 5; i++)
      rd_chk(8'(i * 4), exp_reg(i, e, c, ee));
    chk(32'({spd, fdx, bp, rdy}), 32'({e.speed, e.duplex, e.backpressure, 1'b1}));
  endtask

  task automatic wait_ready;
    while (rdy !== 1'b1) @(negedge clk);
  endtask

  task automatic apply_reset(input p1ss_pkg::p1ss_strap_t p);
    @(posedge clk);
    rstn <= 1'b0;
    pins <= p;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    wait_ready();
  endtask

  // loader pulse, then the two-edge reseed walk plus margin
  task automatic ld(input logic dig, input logic valid, input p1ss_pkg::p1ss_strap_t s);
    u_ldr.pulse(dig, valid, s);
    repeat (3) @(posedge clk);
    @(negedge clk);
    wait_ready();
  endtask

  task automatic s_power_up;
    apply_reset(4'h5);
    check_all(4'h5, 4'h5, 1'b0);
    rd_chk(8'h14, 32'h0);
    chk(32'({txp, rxp}), 32'h0);
  endtask

  task automatic s_sw_write;
    logic [31:0] r;
    wb(1'b1, 8'h0c, 4'h1, 32'hb, r);
    rd_chk(8'h0c, 32'hb);
    chk(32'({txp, rxp}), 32'h3);
    wb(1'b1, 8'h08, 4'h1, 32'he0, r);
    rd_chk(8'h08, 32'he0);
    wb(1'b1, 8'h04, 4'h1, 32'h20, r);
    rd_chk(8'h04, 32'h20);
    // basic control only opens to lane 1
    wb(1'b1, 8'h00, 4'h1, 32'h2000, r);
    rd_chk(8'h00, 32'h100);
    wb(1'b1, 8'h00, 4'h2, 32'h2000, r);
    repeat (2) @(negedge clk);
    chk(32'({spd, fdx, txp, rxp}), 32'h8);
  endtask

  // new pin levels must not be picked up by a reload
  task automatic s_override;
    @(posedge clk);
    pins <= 4'hf;
    ld(1'b0, 1'b1, 4'ha);
    check_all(4'ha, 4'h5, 1'b1);
  endtask

  task automatic s_restore;
    ld(1'b1, 1'b0, 4'h0);
    check_all(4'h5, 4'h5, 1'b0);
    ld(1'b0, 1'b1, 4'h6);
    check_all(4'h6, 4'h5, 1'b1);
    ld(1'b0, 1'b0, 4'h6);
    check_all(4'h5, 4'h5, 1'b0);
  endtask

  task automatic s_repower;
    for (int i = 0; i < 4; i++)
    begin
      apply_reset(4'(i * 5));
      check_all(4'(i * 5), 4'(i * 5), 1'b0);
    end
  endtask

  // main sequence
  initial
  begin
    rstn = 1'b0;
    pins = 4'h5;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    s_power_up();
    s_sw_write();
    s_override();
    s_restore();
    s_repower();
    end_of_test();
  end
endmodule // p1ss_top_tb
